// file: core/fsp_ctrl.sv
// flash self-program controller with apb control register
`timescale 1ns/1ns
`include "fsp_params.svh"

// Operation
// - erase page: code 03, store within four
// - erase uses only the page index
// - core halted during erase and write
// - load word: code 01, store within four
// - buffer clears: page write, reenable, reset
// - eeprom write discards loaded buffer data
// - write page: code 05, store within four
// - word and page fields; byte bit Z0
// - store accepted from any flash address
// - eeprom busy blocks programming and fuse reads
// - pointer 0001 with select returns lock
// - select and enable self-clear on expiry
// - pointer 0000 returns fuse low byte
// - pointer 0003 returns fuse high byte
// - pointer 0002 returns extended fuse byte
// - programmed bits read zero, else one
// - without select, load returns flash contents
// - system reset never aborts flash write
// - enable stays set until operation ends
// - undefined command codes have no effect
module fsp_ctrl
  import fsp_pkg::*;
#(
  parameter int WORD_BITS = 5,
  parameter int PROG_CYC  =
    (`FSP_PROG_US * `FSP_CLK_KHZ + 999) / 1000
) (
  input  wire logic                 clock,
  input  wire logic                 reset_n,
  input  wire logic                 sys_reset_req,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire fsp_core_req_type     core_req,
  output logic                      core_halt,
  output logic [7:0]                load_data,
  output logic                      load_valid,
  input  wire logic                 eeprom_write_busy,
  input  wire logic                 eeprom_write_start,
  input  wire fsp_fuse_type         fuses,
  output logic [15:0]               flash_rd_addr,
  input  wire logic [7:0]           flash_rd_byte,
  output logic                      flash_erase,
  output logic                      flash_write,
  output logic [14-WORD_BITS:0]     flash_page,
  input  wire logic [WORD_BITS-1:0] flash_buf_idx,
  output logic [15:0]               flash_buf_word,
  output logic                      flash_buf_valid
);

  localparam int PW = 15 - WORD_BITS;
  localparam logic [16:0] PROG_N = 17'(PROG_CYC);

  logic [`FSP_CMD_W-1:0] cmd_ff;
  logic [2:0]            age_ff;
  fsp_state_type         state_ff;
  logic [16:0]           tmr_ff;
  logic [PW-1:0]         page_ff;
  logic [7:0]            load_data_ff;
  logic                  load_valid_ff;
  logic                  ctrl_wr;
  logic                  apb_acc;
  logic                  cmd_ok;
  logic                  busy;
  logic                  spm_hit;
  logic                  lpm_fuse;
  logic                  op_done;
  logic                  buf_clear;
  logic                  buf_wr;
  logic                  buf_used;
  logic [`FSP_CMD_W-1:0] wr_cmd;
  logic [7:0]            fuse_byte;

  // apb decode; the slave always answers in the access cycle
  always_comb
  begin
    apb_acc = psel && penable;
    wr_cmd  = pwdata[`FSP_CMD_W-1:0];
    pready  = 1'b1;
    pslverr = apb_acc &&
      (paddr != `FSP_OFS_CTRL) && (paddr != `FSP_OFS_STATUS);
  end

  // only the five defined codes are taken
  always_comb
  begin
    case (wr_cmd)
      `FSP_CMD_LOAD,
      `FSP_CMD_ERASE,
      `FSP_CMD_WRITE,
      `FSP_CMD_FUSE,
      `FSP_CMD_REEN: cmd_ok = 1'b1;
      default:       cmd_ok = 1'b0;
    endcase
  end

  // control write is taken only when idle
  always_comb
  begin
    busy    = (state_ff != FSP_IDLE);
    ctrl_wr = apb_acc && pwrite && (paddr == `FSP_OFS_CTRL) &&
              cmd_ok && !busy && !eeprom_write_busy;
  end

  // read data for the two mapped registers
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (apb_acc && !pwrite)
    begin
      case (paddr)
        `FSP_OFS_CTRL:
          prdata[`FSP_CMD_W-1:0] = cmd_ff;
        `FSP_OFS_STATUS:
        begin
          prdata[`FSP_ST_BUSY]    = busy;
          prdata[`FSP_ST_EEBUSY]  = eeprom_write_busy;
          prdata[`FSP_ST_BUFUSED] = buf_used;
        end
        default:
          prdata = 32'h0000_0000;
      endcase
    end
  end

  // store and load qualification
  always_comb
  begin
    // no address check on the store instruction
    spm_hit  = core_req.store_prog && !busy &&
               (cmd_ff != `FSP_CMD_NONE) &&
               (age_ff < `FSP_SPM_WIN) && !eeprom_write_busy;
    // fuse read needs load within three cycles
    lpm_fuse = core_req.load_prog &&
               (cmd_ff == `FSP_CMD_FUSE) &&
               (age_ff < `FSP_LPM_WIN) && !eeprom_write_busy;
    op_done  = busy && (tmr_ff == 17'h00001);
  end

  // window counter, restarted by each accepted write
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      age_ff <= 3'h0;
    else if (ctrl_wr)
      age_ff <= 3'h0;
    else if (age_ff < `FSP_SPM_WIN)
      age_ff <= age_ff + 3'h1;
  end

  // pending command bits and their self-clearing
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      cmd_ff <= `FSP_CMD_NONE;
    // enable held while the array operation runs
    else if (busy)
    begin
      if (op_done)
        cmd_ff <= `FSP_CMD_NONE;
    end
    else if (sys_reset_req)
      cmd_ff <= `FSP_CMD_NONE;
    else if (ctrl_wr)
      cmd_ff <= wr_cmd;
    else if (lpm_fuse)
      cmd_ff <= `FSP_CMD_NONE;
    else if (spm_hit && (cmd_ff != `FSP_CMD_ERASE) &&
             (cmd_ff != `FSP_CMD_WRITE))
      cmd_ff <= `FSP_CMD_NONE;
    // clear when the window runs out
    else if ((cmd_ff == `FSP_CMD_FUSE) &&
             (age_ff >= `FSP_LPM_WIN))
      cmd_ff <= `FSP_CMD_NONE;
    // other commands expire after four cycles
    else if (age_ff >= `FSP_SPM_WIN)
      cmd_ff <= `FSP_CMD_NONE;
  end

  // operation state and programming timer
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_ff <= FSP_IDLE;
      tmr_ff   <= 17'h00000;
    end
    // system reset does not touch a running operation
    else if (busy)
    begin
      tmr_ff <= tmr_ff - 17'h00001;
      if (op_done)
        state_ff <= FSP_IDLE;
    end
    // erase starts on a store inside the window
    else if (spm_hit && (cmd_ff == `FSP_CMD_ERASE))
    begin
      state_ff <= FSP_ERASE;
      tmr_ff   <= PROG_N;
    end
    // page write starts the same way
    else if (spm_hit && (cmd_ff == `FSP_CMD_WRITE))
    begin
      state_ff <= FSP_WRITE;
      tmr_ff   <= PROG_N;
    end
  end

  // page latch taken from the high pointer bits
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      page_ff <= '0;
    // word and byte bits dropped for erase
    else if (spm_hit && !busy &&
             ((cmd_ff == `FSP_CMD_ERASE) ||
              (cmd_ff == `FSP_CMD_WRITE)))
      page_ff <= core_req.pointer[15:WORD_BITS+1];
  end

  // buffer write and clear conditions
  always_comb
  begin
    // load places the word at the word field
    buf_wr    = spm_hit && (cmd_ff == `FSP_CMD_LOAD);
    // clear on page write end, reenable write, reset
    // an eeprom write discards the loaded data
    buf_clear = sys_reset_req || eeprom_write_start ||
                (ctrl_wr && (wr_cmd == `FSP_CMD_REEN)) ||
                (op_done && (state_ff == FSP_WRITE));
  end

  // temporary page buffer
  fsp_page_buf #(
    .WORDS (1 << WORD_BITS),
    .IW    (WORD_BITS)
  ) u_buf (
    .clock    (clock),
    .reset_n  (reset_n),
    .clear    (buf_clear),
    .wr_en    (buf_wr),
    // word field sits above the byte bit
    .wr_idx   (core_req.pointer[WORD_BITS:1]),
    .wr_data  (core_req.data_word_pair),
    .rd_idx   (flash_buf_idx),
    .rd_data  (flash_buf_word),
    .rd_valid (flash_buf_valid),
    .any_used (buf_used)
  );

  // fuse and lock byte chosen by the pointer
  always_comb
  begin
    case (core_req.pointer)
      `FSP_Z_FUSE_LOW:  fuse_byte = fuses.fuse_low_value;
      `FSP_Z_LOCK:      fuse_byte = fuses.lock_value;
      `FSP_Z_FUSE_EXT:  fuse_byte = fuses.fuse_extended_value;
      `FSP_Z_FUSE_HIGH: fuse_byte = fuses.fuse_high_value;
      default:          fuse_byte = 8'hFF;
    endcase
  end

  // load-program answer, one cycle after the request
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      load_data_ff  <= 8'h00;
      load_valid_ff <= 1'b0;
    end
    else
    begin
      load_valid_ff <= core_req.load_prog && !busy;
      // bytes passed unchanged, zero means programmed
      if (lpm_fuse)
        load_data_ff <= fuse_byte;
      // otherwise flash byte at the full pointer
      else if (core_req.load_prog)
        load_data_ff <= flash_rd_byte;
    end
  end

  // outputs toward core and flash array
  always_comb
  begin
    load_data     = load_data_ff;
    load_valid    = load_valid_ff;
    flash_page    = page_ff;
    flash_rd_addr = core_req.pointer;
    // core halted for the whole erase or write
    core_halt     = busy;
    flash_erase   = (state_ff == FSP_ERASE);
    flash_write   = (state_ff == FSP_WRITE);
  end

endmodule : fsp_ctrl

// file: core/fsp_page_buf.sv
// temporary page buffer of flip-flops with per-word valid
`timescale 1ns/1ns
module fsp_page_buf
  import fsp_pkg::*;
#(
  parameter int WORDS = 32,
  parameter int IW    = 5
) (
  input  wire logic          clock,
  input  wire logic          reset_n,
  input  wire logic          clear,
  input  wire logic          wr_en,
  input  wire logic [IW-1:0] wr_idx,
  input  wire logic [15:0]   wr_data,
  input  wire logic [IW-1:0] rd_idx,
  output logic [15:0]        rd_data,
  output logic               rd_valid,
  output logic               any_used
);

  logic [15:0]      word_ff [WORDS];
  logic [WORDS-1:0] used_ff;

  // one storage word per entry, cleared to all ones like erased flash
  for (genvar i = 0; i < WORDS; i++)
  begin : g_word
    always_ff @(posedge clock or negedge reset_n)
    begin
      if (!reset_n)
      begin
        word_ff[i] <= 16'hFFFF;
        used_ff[i] <= 1'b0;
      end
      else if (clear)
      begin
        word_ff[i] <= 16'hFFFF;
        used_ff[i] <= 1'b0;
      end
      else if (wr_en && (wr_idx == IW'(i)))
      begin
        word_ff[i] <= wr_data;
        used_ff[i] <= 1'b1;
      end
    end
  end

  // read side toward the flash array
  always_comb
  begin
    rd_data  = word_ff[rd_idx];
    rd_valid = used_ff[rd_idx];
    any_used = |used_ff;
  end

endmodule : fsp_page_buf

// file: core/fsp_params.svh
// constants of the flash self-program controller
`ifndef FSP_PARAMS_SVH
`define FSP_PARAMS_SVH

// register byte offsets
`define FSP_OFS_CTRL    12'h000
`define FSP_OFS_STATUS  12'h004

// command codes in the low five control bits
`define FSP_CMD_W       5
`define FSP_CMD_NONE    5'h00
`define FSP_CMD_LOAD    5'h01
`define FSP_CMD_ERASE   5'h03
`define FSP_CMD_WRITE   5'h05
`define FSP_CMD_FUSE    5'h09
`define FSP_CMD_REEN    5'h11

// status bit positions
`define FSP_ST_BUSY     0
`define FSP_ST_EEBUSY   1
`define FSP_ST_BUFUSED  2

// fuse and lock pointer values
`define FSP_Z_FUSE_LOW  16'h0000
`define FSP_Z_LOCK      16'h0001
`define FSP_Z_FUSE_EXT  16'h0002
`define FSP_Z_FUSE_HIGH 16'h0003

// acceptance windows in clock cycles
`define FSP_SPM_WIN     3'h4
`define FSP_LPM_WIN     3'h3

// clock rate and least programming time
`define FSP_CLK_KHZ     25000
`define FSP_PROG_US     3700

`endif

// file: core/fsp_pkg.sv
// types shared by the flash self-program controller
package fsp_pkg;

  // request from the processor core
  typedef struct packed {
    logic        store_prog;  // store-program instruction strobe
    logic        load_prog;   // load-program instruction strobe
    logic [15:0] pointer;     // address pointer
    logic [15:0] data_word_pair;
  } fsp_core_req_type;

  // fuse and lock bytes, zero means programmed
  typedef struct packed {
    logic [7:0] fuse_low_value;
    logic [7:0] fuse_high_value;
    logic [7:0] fuse_extended_value;
    logic [7:0] lock_value;
  } fsp_fuse_type;

  // flash operation state
  typedef enum logic [1:0] {
    FSP_IDLE  = 2'b00,
    FSP_ERASE = 2'b01,
    FSP_WRITE = 2'b10
  } fsp_state_type;

endpackage : fsp_pkg

// file: testbench/flash_self_program_control_tb_top.sv
// self-checking bench of the flash self-program controller
`timescale 1ns/1ns
module flash_self_program_control_tb_top;
  import fsp_pkg::*;
  localparam int    PC = 8;
  logic             clock = 1'h0, reset_n = 1'h0, srst = 1'h0;
  logic             psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0]      paddr = 12'h000;
  logic [31:0]      pwdata = 32'h0, prdata, rd;
  logic             pready, pslverr, err, halt, ld_v, fe, fw, bv;
  logic             ee_busy = 1'h0, ee_go = 1'h0, go_st = 1'h0, go_ld = 1'h0;
  logic [15:0]      ptr = 16'h0, dat = 16'h0, rs = 16'h1FF3, fa, bw, pg;
  logic [15:0]      wd [4];
  logic [7:0]       ld_d;
  logic [9:0]       page;
  logic [4:0]       bidx = 5'h00;
  fsp_core_req_type req;
  fsp_fuse_type     fuses;
  int               bad_count = 0, checked = 0, cyc = 0, n, hn;
  always #20 clock = ~clock;
  fsp_core_model u_core (.core_halt(halt), .go_store(go_st),
    .go_load(go_ld), .ptr(ptr), .dat(dat), .core_req(req));
  fsp_ctrl #(.PROG_CYC(PC)) u_dut (.clock(clock), .reset_n(reset_n),
    .sys_reset_req(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_req(req), .core_halt(halt), .load_data(ld_d),
    .load_valid(ld_v), .eeprom_write_busy(ee_busy),
    .eeprom_write_start(ee_go), .fuses(fuses), .flash_rd_addr(fa),
    .flash_rd_byte(fa[7:0] ^ 8'hA5), .flash_erase(fe), .flash_write(fw),
    .flash_page(page), .flash_buf_idx(bidx), .flash_buf_word(bw),
    .flash_buf_valid(bv));
  // halt cycles and the hang limit
  always @(posedge clock)
  begin
    cyc++;
    hn += halt;
    if (cyc == 5000)
    begin
      bad_count++;
      finish_test();
    end
  end
  function automatic logic [15:0] rnd();
    rs = {rs[14:0], rs[15] ^ rs[13] ^ rs[12] ^ rs[10]};
    return rs;
  endfunction : rnd
  function automatic logic [7:0] fuse_exp(input logic [1:0] p);
    case (p)
      2'h0: return fuses.fuse_low_value;
      2'h1: return fuses.lock_value;
      2'h2: return fuses.fuse_extended_value;
      default: return fuses.fuse_high_value;
    endcase
  endfunction : fuse_exp
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    @(posedge clock);
    while (pready !== 1'h1)
      @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // control write, then one instruction k cycles into the window
  task automatic cmd(input logic [4:0] c, input logic [15:0] p, input int k,
                     input logic ld);
    ptr <= p;
    dat <= rnd();
    apb(1'h1, 12'h000, {27'h0, c});
    repeat (k) @(posedge clock);
    go_ld <= ld;
    go_st <= !ld;
    @(posedge clock);
    go_ld <= 1'h0;
    go_st <= 1'h0;
    @(negedge clock);
  endtask : cmd
  task automatic buf_chk(input logic [4:0] i, input logic [16:0] exp);
    @(posedge clock);
    bidx <= i;
    @(negedge clock);
    chk({bv, bw & {16{bv}}}, exp);
  endtask : buf_chk
  task automatic wait_idle();
    for (n = 0; halt !== 1'h0 && n < 100; n++)
      @(posedge clock);
    @(negedge clock);
  endtask : wait_idle
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  // main sequence
  initial
  begin
    fuses = {rnd(), rnd()};
    repeat (3) @(posedge clock);
    reset_n <= 1'h1;
    apb(1'h0, 12'h004, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, 12'h008, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      cmd(5'h01, {rs[15:6], i[4:0], rs[0]}, int'(rs[1:0]), 1'h0);
      wd[i] = dat;
    end
    for (int i = 0; i < 4; i++)
      buf_chk(i[4:0], {1'h1, wd[i]});
    pg = rnd();
    hn = 0;
    cmd(5'h03, pg, 0, 1'h0);
    chk({halt, fe, page}, {2'h3, pg[15:6]});
    apb(1'h0, 12'h000, 32'h0);
    chk(rd[4:0], 5'h03);
    wait_idle();
    chk(hn, PC);
    hn = 0;
    cmd(5'h05, {pg[15:6], 6'h00}, 3, 1'h0);
    chk({halt, fw, page}, {2'h3, pg[15:6]});
    @(posedge clock);
    srst <= 1'h1;
    @(posedge clock);
    srst <= 1'h0;
    wait_idle();
    chk(hn, PC);
    buf_chk(5'h01, 17'h0);
    hn = 0;
    cmd(5'h03, rnd(), 4, 1'h0);
    cmd(5'h02, rnd(), 0, 1'h0);
    @(posedge clock);
    ee_busy <= 1'h1;
    cmd(5'h03, rnd(), 0, 1'h0);
    cmd(5'h09, 16'h0000, 0, 1'h1);
    chk(ld_d, 8'hA5);
    @(posedge clock);
    ee_busy <= 1'h0;
    chk(hn, 0);
    for (int i = 0; i < 4; i++)
    begin
      cmd(5'h09, i[15:0], int'(rs[1:0]) % 3, 1'h1);
      chk({ld_v, ld_d}, {1'h1, fuse_exp(i[1:0])});
    end
    cmd(5'h09, 16'h0001, 3, 1'h1);
    chk(ld_d, 8'hA4);
    cmd(5'h00, 16'h0012, 0, 1'h1);
    chk({ld_v, ld_d}, 9'h1B7);
    for (int m = 0; m < 3; m++)
    begin
      cmd(5'h01, 16'h0002, 0, 1'h0);
      @(posedge clock);
      ee_go <= m == 0;
      srst <= m == 1;
      @(posedge clock);
      ee_go <= 1'h0;
      srst <= 1'h0;
      if (m == 2)
        cmd(5'h11, 16'h0000, 0, 1'h1);
      buf_chk(5'h01, 17'h0);
    end
    finish_test();
  end
endmodule : flash_self_program_control_tb_top
bind fsp_ctrl fsp_ctrl_chk #(.WORD_BITS(WORD_BITS), .PROG_CYC(PROG_CYC))
  u_chk (.*);

// file: testbench/fsp_core_model.sv
// processor core issuing store and load program instructions
`timescale 1ns/1ns
module fsp_core_model
  import fsp_pkg::*;
(
  input  wire logic        core_halt,
  input  wire logic        go_store,
  input  wire logic        go_load,
  input  wire logic [15:0] ptr,
  input  wire logic [15:0] dat,
  output fsp_core_req_type core_req
);
  // word order, page reuse, erase first: set by bench
  // instructions in the window; a halted core issues none
  assign core_req.store_prog     = go_store && !core_halt;
  assign core_req.load_prog      = go_load && !core_halt;
  assign core_req.pointer        = ptr;
  assign core_req.data_word_pair = dat;
endmodule : fsp_core_model

// file: testbench/fsp_ctrl_chk.sv
// port assertions of the flash self-program controller
`timescale 1ns/1ns
module fsp_ctrl_chk
  import fsp_pkg::*;
#(
  parameter int WORD_BITS = 5,
  parameter int PROG_CYC  = 8
) (
  input wire logic                 clock,
  input wire logic                 reset_n,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire fsp_core_req_type     core_req,
  input wire logic                 core_halt,
  input wire logic [7:0]           load_data,
  input wire logic                 load_valid,
  input wire logic                 eeprom_write_busy,
  input wire logic                 eeprom_write_start,
  input wire logic [7:0]           flash_rd_byte,
  input wire logic                 flash_erase,
  input wire logic                 flash_write,
  input wire logic [14-WORD_BITS:0] flash_page,
  input wire logic                 flash_buf_valid
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic [15:0] halt_cnt_ff;
  wire         ctl_wr = psel && penable && pwrite && paddr == 12'h000;
  // accepted control write, and a stretch with none
  sequence s_cmd(logic [4:0] c);
    ctl_wr && pwdata[4:0] == c && !core_halt && !eeprom_write_busy;
  endsequence
  sequence s_quiet;
    !ctl_wr [*4];
  endsequence
  // length of the current halt
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
      halt_cnt_ff <= 16'h0000;
    else
      halt_cnt_ff <= core_halt ? halt_cnt_ff + 16'h0001 : 16'h0000;
  a_halt_mirror: assert property (
    core_halt == (flash_erase || flash_write)) else $error("halt mismatch");
  a_halt_len: assert property (
    $fell(core_halt) |-> halt_cnt_ff == PROG_CYC) else $error("bad op length");
  a_erase_start: assert property (
    s_cmd(5'h03) ##1 (core_req.store_prog && !eeprom_write_busy) |=>
    flash_erase && flash_page == $past(core_req.pointer[15:WORD_BITS+1]))
    else $error("erase not started");
  a_late_refused: assert property (
    s_cmd(5'h03) ##1 (!ctl_wr && !core_req.store_prog) [*4] ##1
    core_req.store_prog |=> !core_halt) else $error("late store taken");
  a_bad_ignored: assert property (
    s_quiet ##1 (ctl_wr && pwdata[4:0] == 5'h02) ##1 core_req.store_prog
    |=> !core_halt) else $error("undefined code acted");
  a_ee_blocks: assert property (
    eeprom_write_busy && core_req.store_prog |=> !$rose(core_halt))
    else $error("store taken during eeprom write");
  a_plain_load: assert property (
    s_cmd(5'h00) ##1 (core_req.load_prog && !core_halt) |=>
    load_valid && load_data == $past(flash_rd_byte))
    else $error("load not from flash");
  a_buf_clear: assert property (
    $fell(flash_write) |-> ##[0:1] !flash_buf_valid)
    else $error("buffer kept after write");
  a_ee_discard: assert property (
    eeprom_write_start && !core_req.store_prog |=> !flash_buf_valid)
    else $error("buffer kept after eeprom write");
endmodule : fsp_ctrl_chk
